// ---- design/modem_baud_defines.svh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  modem status and baud generator block.
  Assumes inclusion by bare name from design files.
*/
`ifndef MODEM_BAUD_DEFINES_SVH
`define MODEM_BAUD_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_MODEM_STATUS 4'h0
`define ADDR_HANDSHAKE_CTRL 4'h4
`define ADDR_DIV_LOW 4'h8
`define ADDR_DIV_HIGH 4'hC

// ----------------------------------------
// Handshake control field positions
// ----------------------------------------
`define HC_DTR_BIT 0
`define HC_RTS_BIT 1
`define HC_USER_A_BIT 2
`define HC_USER_B_BIT 3
`define HC_LOOP_BIT 4
`define HC_AUTO_FLOW_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HC_RESET 8'h00
`define DIV_RESET 16'h0001
`define DIVIDE_16X 16

`endif

// ---- design/modem_baud_pkg.sv ----
/*
  Types shared by the modem status and baud generator modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package modem_baud_pkg;
  typedef logic [15:0] divisor_t;
  typedef logic [7:0] byte_t;
endpackage

// ---- design/baud_link_if.sv ----
/*
  Carrier between register logic and the baud divider.
  Assumes both ends share core_clk.
*/
interface baud_link_if;
  import modem_baud_pkg::*;
  divisor_t divisor;
  logic reload;
  logic tick16;
  modport ctrl (output divisor, output reload, input tick16);
  modport gen (input divisor, input reload, output tick16);
endinterface

// ---- design/baud_divider.sv ----
/*
  Divides core_clk by a 16-bit divisor into a one-cycle enable at sixteen
  times the bit rate, with a 16-bit down-counter reloaded on demand.
  Assumes the divisor is never zero; zero is served as one.
*/
`include "modem_baud_defines.svh"
module baud_divider
  import modem_baud_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link to register logic
  baud_link_if.gen link
);
  initial begin
    if (DIV_WIDTH != 16) $error("baud_divider serves only a 16-bit divisor");
  end

  divisor_t count_reg, count_next;
  logic tick_reg, tick_next;

  always_comb begin
    count_next = count_reg - 16'h0001;
    tick_next = 1'b0;
    if (link.reload) begin
      count_next = link.divisor;
    end else if (count_reg <= 16'h0001) begin
      count_next = link.divisor;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_reg <= `DIV_RESET;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign link.tick16 = tick_reg;
endmodule

// ---- design/modem_status_baud.sv ----
/*
  Modem status reporting, handshake control and baud generator for one
  serial channel, with an Avalon-MM register slave.
  Assumes handshake inputs are active-low pins synchronous to core_clk and
  that the host programs both divisor bytes before using the baud enable.
*/
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`include "modem_baud_defines.svh"

// What this block does
// - Reading modem status clears all four change flags.
// - Clear-to-send change sets bit 0, suppressed while auto flow is on.
// - Data-set-ready change sets bit 1.
// - Ring input rising low to high sets bit 2.
// - Carrier-detect change sets bit 3.
// - Bits 4 to 7 return inverted CTS, DSR, RI, DCD inputs.
// - Loopback: bits 4-7 equal control bits 1, 0, 2, 3.
// - Baud generator divides clock by divisor 1 to 65535, giving 16x rate.
// - Divisor is 16 bits in two separately writable byte registers.
// - Writing either divisor byte reloads the baud down-counter.
// - Loopback routes control outputs inward and forces output pins high.
// - Control bit 5 enables auto flow; bit 1 adds auto request-to-send.
module modem_status_baud
  import modem_baud_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Modem handshake inputs, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  // Modem handshake outputs, active low
  output logic dtr_n,
  output logic rts_n,
  output logic user_output_a_n,
  output logic user_output_b_n,
  // Flow control and baud enable
  output logic auto_cts_enable,
  output logic auto_rts_enable,
  output logic baud_tick16
);
  baud_link_if link ();

  baud_divider #(
    .DIV_WIDTH(16)
  ) u_div (
    .core_clk(core_clk),
    .reset(reset),
    .link(link)
  );

  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  byte_t hc_reg, hc_next;
  byte_t div_lo_reg, div_lo_next;
  byte_t div_hi_reg, div_hi_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;
  logic reload_reg, reload_next;
  logic access;
  logic status_read;

  // Waitrequest is low for one cycle per access: one-cycle answer
  assign access = (avs_read | avs_write) & wait_reg;
  assign status_read = access & avs_read & (avs_address == `ADDR_MODEM_STATUS);

  // ----------------------------------------
  // Modem status state
  // ----------------------------------------
  logic [3:0] line_reg, line_next;
  logic [3:0] delta_reg, delta_next;
  logic [3:0] live;
  logic loop_on;
  logic auto_flow;
  byte_t modem_line_status;

  assign loop_on = hc_reg[`HC_LOOP_BIT];
  assign auto_flow = hc_reg[`HC_AUTO_FLOW_BIT];

  // Active-high view of CTS, DSR, RI, DCD
  always_comb begin
    if (loop_on) begin
      live = {hc_reg[`HC_USER_B_BIT], hc_reg[`HC_USER_A_BIT],
              hc_reg[`HC_DTR_BIT], hc_reg[`HC_RTS_BIT]};
    end else begin
      live = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
    end
  end

  always_comb begin
    line_next = live;
    delta_next = delta_reg;
    if (status_read) begin
      delta_next = 4'h0;
    end
    // Sets placed after the clear so they win
    if ((live[0] != line_reg[0]) && !auto_flow) begin
      delta_next[0] = 1'b1;
    end
    if (live[1] != line_reg[1]) begin
      delta_next[1] = 1'b1;
    end
    // Ring pin going low to high means the active view falls
    if (line_reg[2] && !live[2]) begin
      delta_next[2] = 1'b1;
    end
    if (live[3] != line_reg[3]) begin
      delta_next[3] = 1'b1;
    end
    if (auto_flow) begin
      delta_next[0] = 1'b0;
    end
  end

  assign modem_line_status = {line_reg, delta_reg};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      line_reg <= 4'h0;
      delta_reg <= 4'h0;
    end else begin
      line_reg <= line_next;
      delta_reg <= delta_next;
    end
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  always_comb begin
    hc_next = hc_reg;
    div_lo_next = div_lo_reg;
    div_hi_next = div_hi_reg;
    rdata_next = rdata_reg;
    reload_next = 1'b0;
    wait_next = 1'b1;
    if (access) begin
      wait_next = 1'b0;
    end
    if (access && avs_write && avs_byteenable[0]) begin
      unique case (avs_address)
        `ADDR_HANDSHAKE_CTRL: begin
          hc_next = {2'b00, avs_writedata[5:0]};
        end
        `ADDR_DIV_LOW: begin
          div_lo_next = avs_writedata[7:0];
          reload_next = 1'b1;
        end
        `ADDR_DIV_HIGH: begin
          div_hi_next = avs_writedata[7:0];
          reload_next = 1'b1;
        end
        default: begin
          hc_next = hc_reg;
        end
      endcase
    end
    if (access && avs_read) begin
      unique case (avs_address)
        `ADDR_MODEM_STATUS: rdata_next = {24'h000000, modem_line_status};
        `ADDR_HANDSHAKE_CTRL: rdata_next = {24'h000000, hc_reg};
        `ADDR_DIV_LOW: rdata_next = {24'h000000, div_lo_reg};
        `ADDR_DIV_HIGH: rdata_next = {24'h000000, div_hi_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hc_reg <= `HC_RESET;
      div_lo_reg <= byte_t'(`DIV_RESET);
      div_hi_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
      wait_reg <= 1'b1;
      reload_reg <= 1'b0;
    end else begin
      hc_reg <= hc_next;
      div_lo_reg <= div_lo_next;
      div_hi_reg <= div_hi_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
      reload_reg <= reload_next;
    end
  end

  // Readdata registered the same edge waitrequest drops, held until the next read
  always_comb begin
    avs_readdata = rdata_reg;
    avs_waitrequest = wait_reg;
  end

  // Zero divisor served as one
  assign link.divisor = ({div_hi_reg, div_lo_reg} == 16'h0000) ? 16'h0001
                        : {div_hi_reg, div_lo_reg};
  assign link.reload = reload_reg;

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  logic [6:0] pins_reg, pins_next;

  always_comb begin
    if (loop_on) begin
      pins_next[3:0] = 4'hF;
    end else begin
      pins_next[3:0] = ~hc_reg[3:0];
    end
    pins_next[4] = auto_flow;
    pins_next[5] = auto_flow & hc_reg[`HC_RTS_BIT];
    pins_next[6] = link.tick16;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pins_reg <= 7'h0F;
    end else begin
      pins_reg <= pins_next;
    end
  end

  always_comb begin
    dtr_n = pins_reg[0];
    rts_n = pins_reg[1];
    user_output_a_n = pins_reg[2];
    user_output_b_n = pins_reg[3];
    auto_cts_enable = pins_reg[4];
    auto_rts_enable = pins_reg[5];
    baud_tick16 = pins_reg[6];
  end
endmodule

// ---- bench/modem_status_baud_assertions.sv ----
/*
  Port assertions for the modem status and baud block.
  Assumes one clock domain; the bind follows the module.
*/
`include "modem_baud_defines.svh"
module modem_status_baud_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Modem lines
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic user_output_a_n,
  input wire logic user_output_b_n,
  // Flow and baud
  input wire logic auto_cts_enable,
  input wire logic auto_rts_enable,
  input wire logic baud_tick16
);
  logic rd_done, wr_done, div_wr, seen_reg, seen_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [15:0] div_reg, div_next, cnt_reg, cnt_next;
  logic [3:0] pin_reg;
  logic [1:0] age_reg, age_next;
  assign rd_done = avs_read && !avs_waitrequest;
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign div_wr = wr_done && avs_address[3] && avs_address[1:0] == 2'h0;
  // Shadow of control, divisor, tick spacing and input age
  always_comb begin
    ctl_next = ctl_reg;
    div_next = div_reg;
    if (wr_done && avs_address == `ADDR_HANDSHAKE_CTRL) ctl_next = avs_writedata[7:0];
    if (div_wr && !avs_address[2]) div_next[7:0] = avs_writedata[7:0];
    if (div_wr && avs_address[2]) div_next[15:8] = avs_writedata[7:0];
    cnt_next = (div_wr || baud_tick16) ? 16'h0001 : cnt_reg + 16'h0001;
    seen_next = !div_wr && (baud_tick16 || seen_reg);
    age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
    if (wr_done || pin_reg != {dcd_n, ri_n, dsr_n, cts_n}) age_next = 2'h0;
  end
  always_ff @(posedge core_clk) begin
    pin_reg <= {dcd_n, ri_n, dsr_n, cts_n};
    if (reset) begin
      {ctl_reg, div_reg, cnt_reg, seen_reg, age_reg} <= {8'h00, 16'h0001, 16'h0001, 3'h0};
    end else begin
      {ctl_reg, div_reg, cnt_reg, seen_reg, age_reg} <= {ctl_next, div_next, cnt_next,
        seen_next, age_next};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("request not answered");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_unmapped_zero: assert property (rd_done && avs_address[1:0] != 2'h0 |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_line_view: assert property (
    rd_done && avs_address == 4'h0 && age_reg == 2'h3 |-> avs_readdata[7:4] == (ctl_reg[4] ?
    {ctl_reg[3], ctl_reg[2], ctl_reg[0], ctl_reg[1]} : ~{dcd_n, ri_n, dsr_n, cts_n}))
    else $error("status line view wrong");
  chk_pins_follow: assert property (age_reg == 2'h3 |->
    {user_output_b_n, user_output_a_n, rts_n, dtr_n} == (ctl_reg[4] ? 4'hF : ~ctl_reg[3:0]))
    else $error("control pins wrong");
  chk_auto_flow: assert property (age_reg == 2'h3 |-> auto_cts_enable == ctl_reg[5] &&
    auto_rts_enable == (ctl_reg[5] && ctl_reg[1])) else $error("auto flow enables wrong");
  chk_tick_period: assert property (baud_tick16 && seen_reg |-> cnt_reg == div_reg)
    else $error("baud tick spacing wrong");
endmodule
bind modem_status_baud modem_status_baud_assertions chk_u (.core_clk, .reset, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .cts_n, .dsr_n, .ri_n, .dcd_n, .dtr_n, .rts_n, .user_output_a_n, .user_output_b_n,
  .auto_cts_enable, .auto_rts_enable, .baud_tick16);

// ---- bench/modem_peer.sv ----
/*
  Modem side: drives the four active-low handshake lines.
  Assumes level bits ordered clear-to-send, set-ready, ring, carrier.
*/
module modem_peer (
  // Clock
  input wire logic core_clk,
  // Asserted line levels
  input wire logic [3:0] level,
  // Lines toward the block
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
  always @(posedge core_clk) {dcd_n, ri_n, dsr_n, cts_n} <= ~level;
endmodule

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the modem status and baud block.
  Assumes modem_peer on the handshake lines and the bound checker.
*/
module tb_top
  import modem_baud_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 0, avs_byteenable = 4'h1, level = 0, p, f, c;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic avs_waitrequest, cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, ua_n, ub_n, acts, arts, tick;
  int err_count = 0, total_checks = 0;
  byte_t q, d;
  always #12.5 core_clk = ~core_clk;
  modem_peer peer_u (.core_clk, .level, .cts_n, .dsr_n, .ri_n, .dcd_n);
  modem_status_baud dut_u (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cts_n, .dsr_n, .ri_n,
    .dcd_n, .dtr_n, .rts_n, .user_output_a_n(ua_n), .user_output_b_n(ub_n),
    .auto_cts_enable(acts), .auto_rts_enable(arts), .baud_tick16(tick));
  task automatic chk(input byte_t got, input byte_t exp);
    total_checks++;
    if (got !== exp) err_count++;
    if (got !== exp) $display("[ERR] %0t got %h expected %h", $time, got, exp);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input byte_t wd);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    for (n = 0; avs_waitrequest !== 1'b0 && n < 40; n++) @(posedge core_clk);
    err_count += (n == 40);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    int n;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    bus(0, 4'h8, 0);
    chk(q, 8'h01);
    bus(0, 4'h6, 0);
    chk(q, 8'h00);
    chk({4'h0, ub_n, ua_n, rts_n, dtr_n}, 8'h0F);
    bus(0, 4'h0, 0);
    $display("reset values done");
    for (int i = 0; i < 5; i++) begin
      p = level;
      level <= (i < 4) ? 4'h1 << i : 4'h0;
      repeat (4) @(posedge core_clk);
      f = ((p ^ level) & 4'hB) | (p & ~level & 4'h4);
      bus(0, 4'h0, 0);
      chk(q, {level, f});
      bus(0, 4'h0, 0);
      chk(q, {level, 4'h0});
    end
    level <= 4'h2;
    @(posedge core_clk);
    bus(0, 4'h0, 0);
    chk(q, 8'h00);
    bus(0, 4'h0, 0);
    chk(q, 8'h22);
    level <= 4'h0;
    repeat (4) @(posedge core_clk);
    bus(0, 4'h0, 0);
    chk(q, 8'h02);
    $display("status lines done");
    bus(1, 4'h4, 8'h20);
    repeat (2) @(posedge core_clk);
    chk({6'h0, arts, acts}, 8'h01);
    bus(1, 4'h4, 8'h22);
    bus(0, 4'h0, 0);
    level <= 4'h1;
    repeat (4) @(posedge core_clk);
    chk({6'h0, arts, acts}, 8'h03);
    chk({4'h0, ub_n, ua_n, rts_n, dtr_n}, 8'h0D);
    bus(0, 4'h0, 0);
    chk(q, 8'h10);
    level <= 4'hF;
    for (int i = 0; i < 2; i++) begin
      c = i ? 4'hA : 4'h5;
      bus(1, 4'h4, {4'h1, c});
      bus(0, 4'h0, 0);
      chk(q & 8'hF0, {c[3], c[2], c[0], c[1], 4'h0});
      chk({4'h0, ub_n, ua_n, rts_n, dtr_n}, 8'h0F);
    end
    bus(1, 4'h4, 8'h00);
    $display("flow and loopback done");
    avs_byteenable <= 4'h0;
    bus(1, 4'h8, 8'h55);
    avs_byteenable <= 4'h1;
    bus(1, 4'hC, 8'h01);
    bus(0, 4'hC, 0);
    chk(q, 8'h01);
    bus(1, 4'hC, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = i == 0 ? 8'h03 : (i == 1 ? 8'h0C : 8'h14);
      bus(1, 4'h8, d);
      bus(1, 4'hC, 8'h00);
      bus(0, 4'h8, 0);
      chk(q, d);
      for (n = 0; tick !== 1'b1 && n < 300; n++) @(posedge core_clk);
      for (n = 0; n == 0 || tick !== 1'b1 && n < 300; n++) @(posedge core_clk);
      chk(n[7:0], d);
    end
    $display("baud done");
    report_and_stop();
  end
endmodule
